/* rtl/ast_defines.svh */
// Named constants for the asynchronous serial transceiver.
`ifndef AST_DEFINES_SVH
`define AST_DEFINES_SVH

`define AST_DIV_W 13
`define AST_OS_LAST 4'hF
`define AST_OS_ZERO 4'h0
`define AST_SAMPLE_A 4'h7
`define AST_SAMPLE_B 4'h8
`define AST_SAMPLE_C 4'h9
`define AST_OS_RATIO 8'h10
`define AST_FRAME8 4'hA
`define AST_FRAME9 4'hB
`define AST_SHIFT_IDLE 12'hFFF
`define AST_BITS_NONE 4'h0
`define AST_BIT_START 4'h0
`define AST_BIT_ONE 4'h1
`define AST_TX_FLAGS_RST 1'b1
`define AST_RX_FLAGS_RST 1'b0
`define AST_IDLE_CNT_RST 8'h00
`define AST_WORD_RST 9'h000
`define AST_PRE_ONE 13'h0001
`define AST_ARM_TX_W 2
`define AST_ARM_RX_W 6

`endif

/* rtl/ast_pkg.sv */
// Types shared by the asynchronous serial transceiver.
package ast_pkg;
    typedef logic [8:0] ast_word_t;
    typedef enum logic [0:0] {
        AST_RX_IDLE,
        AST_RX_FRAME
    } ast_rx_state_e;
endpackage

/* rtl/ast_uart.sv */
// Full-duplex asynchronous serial transceiver with baud prescaler and status flags.
`timescale 1ns/1ps
`default_nettype none
`include "ast_defines.svh"

module ast_uart (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [`AST_DIV_W-1:0] baud_divisor,
    input wire logic word_9bit,
    input wire logic parity_enable,
    input wire logic parity_odd,
    input wire logic tx_enable,
    input wire logic rx_enable,
    input wire logic send_break,
    input wire logic rx_sleep_set,
    input wire logic tx_holding_irq_en,
    input wire logic tx_complete_irq_en,
    input wire logic rx_irq_en,
    input wire logic idle_irq_en,
    input wire logic status_rd,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire ast_pkg::ast_word_t wr_data,
    input wire logic serial_in,
    output logic serial_out,
    output logic tx_pin_oe_n,
    output ast_pkg::ast_word_t rx_holding_reg,
    output logic tx_holding_empty,
    output logic tx_complete,
    output logic rx_holding_full,
    output logic idle_flag,
    output logic overrun_flag,
    output logic noise_flag,
    output logic framing_flag,
    output logic parity_flag,
    output logic rx_active_flag,
    output logic rx_sleep,
    output logic irq_req
);
    import ast_pkg::*;

    function automatic logic ast_parity(input logic [7:0] bits, input logic odd);
        ast_parity = (^bits) ^ odd;
    endfunction

    function automatic logic ast_major(input logic a, input logic b, input logic c);
        ast_major = (a & b) | (a & c) | (b & c);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Baud prescaler: divisor gives 32x tick, halved to a 16x sample tick.

    logic [`AST_DIV_W-1:0] pre_cnt_r;
    logic pre_half_r;
    logic os_tick_r;
    logic [3:0] tx_os_r;
    logic tx_tick;
    logic [3:0] frame_len;

    assign frame_len = word_9bit ? `AST_FRAME9 : `AST_FRAME8;
    assign tx_tick = os_tick_r & (tx_os_r == `AST_OS_LAST);

    // A zero divisor stops the prescaler rather than running at full rate.
    always_ff @(posedge mclk) begin
        if (reset) begin
            pre_cnt_r <= '0;
            pre_half_r <= 1'b0;
            os_tick_r <= 1'b0;
        end else begin
            os_tick_r <= 1'b0;
            if (baud_divisor == '0) begin
                pre_cnt_r <= '0;
            end else if (pre_cnt_r <= `AST_PRE_ONE) begin
                pre_cnt_r <= baud_divisor;
                pre_half_r <= ~pre_half_r;
                os_tick_r <= pre_half_r;
            end else begin
                pre_cnt_r <= pre_cnt_r - `AST_PRE_ONE;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_os_r <= `AST_OS_ZERO;
        end else if (os_tick_r) begin
            tx_os_r <= tx_os_r + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Clearing sequence: a status read arms the flags that were set then.

    logic [`AST_ARM_TX_W-1:0] tx_arm_r;
    logic [`AST_ARM_RX_W-1:0] rx_arm_r;
    logic [`AST_ARM_TX_W-1:0] tx_clr;
    logic [`AST_ARM_RX_W-1:0] rx_clr;

    assign tx_clr = data_wr ? tx_arm_r : '0;
    assign rx_clr = data_rd ? rx_arm_r : '0;

    // Arming only set flags keeps an event that lands after the read alive.
    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_arm_r <= '0;
            rx_arm_r <= '0;
        end else begin
            if (data_wr) begin
                tx_arm_r <= '0;
            end
            if (data_rd) begin
                rx_arm_r <= '0;
            end
            if (status_rd) begin
                tx_arm_r <= {tx_complete, tx_holding_empty};
                rx_arm_r <= {idle_flag, overrun_flag, noise_flag,
                             framing_flag, parity_flag, rx_holding_full};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter.

    ast_word_t tx_hold_r;
    logic tx_hold_full_r;
    logic [11:0] tx_shift_r;
    logic [3:0] tx_left_r;
    logic tx_busy_r;
    logic tx_en_prev_r;
    logic tx_preamble_r;
    ast_word_t tx_word;
    logic [11:0] tx_frame;

    always_comb begin
        tx_word = tx_hold_r;
        if (parity_enable) begin
            if (word_9bit) begin
                tx_word[8] = ast_parity(tx_hold_r[7:0], parity_odd);
            end else begin
                tx_word[7] = ast_parity({1'b0, tx_hold_r[6:0]}, parity_odd);
            end
        end
        if (word_9bit) begin
            tx_frame = {2'b11, tx_word, 1'b0};
        end else begin
            tx_frame = {3'b111, tx_word[7:0], 1'b0};
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_en_prev_r <= 1'b0;
            tx_preamble_r <= 1'b0;
        end else begin
            tx_en_prev_r <= tx_enable;
            if (tx_enable & ~tx_en_prev_r) begin
                tx_preamble_r <= 1'b1;
            end else if (tx_tick & (tx_left_r == `AST_BITS_NONE) & tx_enable) begin
                tx_preamble_r <= 1'b0;
            end
        end
    end

    // A frame in flight always runs to its end; the enable is only consulted
    // between frames, so only reset can cut a character short.
    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_shift_r <= `AST_SHIFT_IDLE;
            tx_left_r <= `AST_BITS_NONE;
            tx_busy_r <= 1'b0;
            tx_hold_full_r <= 1'b0;
            tx_hold_r <= `AST_WORD_RST;
            serial_out <= 1'b1;
            tx_holding_empty <= `AST_TX_FLAGS_RST;
            tx_complete <= `AST_TX_FLAGS_RST;
        end else begin
            if (tx_clr[0]) begin
                tx_holding_empty <= 1'b0;
            end
            if (tx_clr[1]) begin
                tx_complete <= 1'b0;
            end
            if (data_wr) begin
                tx_hold_r <= wr_data;
                tx_hold_full_r <= 1'b1;
            end
            if (tx_tick) begin
                if (tx_left_r != `AST_BITS_NONE) begin
                    serial_out <= tx_shift_r[0];
                    tx_shift_r <= {1'b1, tx_shift_r[11:1]};
                    tx_left_r <= tx_left_r - 4'h1;
                end else if (~tx_enable) begin
                    serial_out <= 1'b1;
                    tx_hold_full_r <= 1'b0;
                    tx_busy_r <= 1'b0;
                    tx_holding_empty <= 1'b1;
                    tx_complete <= 1'b1;
                end else if (tx_preamble_r) begin
                    serial_out <= 1'b1;
                    tx_shift_r <= `AST_SHIFT_IDLE;
                    tx_left_r <= frame_len - 4'h1;
                    tx_busy_r <= 1'b1;
                end else if (send_break) begin
                    // Low bits of the break shift are zeros through the stop position; the bits above it are high.
                    serial_out <= 1'b0;
                    tx_shift_r <= `AST_SHIFT_IDLE << (frame_len - 4'h1);
                    tx_left_r <= frame_len;
                    tx_busy_r <= 1'b1;
                end else if (tx_hold_full_r) begin
                    serial_out <= tx_frame[0];
                    tx_shift_r <= {1'b1, tx_frame[11:1]};
                    tx_left_r <= frame_len - 4'h1;
                    tx_busy_r <= 1'b1;
                    if (~data_wr) begin
                        tx_hold_full_r <= 1'b0;
                    end
                    tx_holding_empty <= 1'b1;
                end else begin
                    serial_out <= 1'b1;
                    if (tx_busy_r) begin
                        tx_complete <= 1'b1;
                    end
                    tx_busy_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            tx_pin_oe_n <= 1'b1;
        end else begin
            tx_pin_oe_n <= ~(tx_enable | tx_busy_r);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Receiver.

    ast_rx_state_e rx_state_r;
    logic [3:0] rx_os_r;
    logic [3:0] rx_bit_r;
    logic rx_samp_a_r;
    logic rx_samp_b_r;
    logic rx_noise_r;
    logic rx_prev_r;
    ast_word_t rx_shift_r;
    logic [7:0] idle_cnt_r;
    logic line_act_r;
    logic rx_maj;
    logic rx_split;
    logic rx_mid;
    logic rx_stop;
    logic rx_done;
    logic rx_par_bad;
    logic idle_event;
    logic [7:0] idle_frame;

    assign rx_mid = os_tick_r & (rx_state_r == AST_RX_FRAME) & (rx_os_r == `AST_SAMPLE_C);
    assign rx_maj = ast_major(rx_samp_a_r, rx_samp_b_r, serial_in);
    assign rx_split = ~((rx_samp_a_r == rx_samp_b_r) & (rx_samp_b_r == serial_in));
    assign rx_stop = rx_bit_r == (frame_len - 4'h1);
    assign rx_done = rx_mid & rx_stop;
    assign idle_frame = `AST_OS_RATIO * {4'h0, frame_len};
    assign idle_event = os_tick_r & serial_in & line_act_r & (rx_state_r == AST_RX_IDLE)
                        & (idle_cnt_r == idle_frame - 8'h01);

    always_comb begin
        if (word_9bit) begin
            rx_par_bad = rx_shift_r[8] != ast_parity(rx_shift_r[7:0], parity_odd);
        end else begin
            rx_par_bad = rx_shift_r[7] != ast_parity({1'b0, rx_shift_r[6:0]}, parity_odd);
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_state_r <= AST_RX_IDLE;
            rx_os_r <= `AST_OS_ZERO;
            rx_bit_r <= `AST_BIT_START;
            rx_samp_a_r <= 1'b1;
            rx_samp_b_r <= 1'b1;
            rx_noise_r <= 1'b0;
            rx_prev_r <= 1'b1;
            rx_shift_r <= `AST_WORD_RST;
        end else if (os_tick_r) begin
            rx_prev_r <= serial_in;
            case (rx_state_r)
                AST_RX_IDLE: begin
                    if (rx_enable & rx_prev_r & ~serial_in) begin
                        rx_state_r <= AST_RX_FRAME;
                        rx_os_r <= 4'h1;
                        rx_bit_r <= `AST_BIT_START;
                        rx_noise_r <= 1'b0;
                        rx_shift_r <= `AST_WORD_RST;
                    end
                end
                AST_RX_FRAME: begin
                    rx_os_r <= rx_os_r + 4'h1;
                    if (rx_os_r == `AST_SAMPLE_A) begin
                        rx_samp_a_r <= serial_in;
                    end
                    if (rx_os_r == `AST_SAMPLE_B) begin
                        rx_samp_b_r <= serial_in;
                    end
                    if (rx_os_r == `AST_SAMPLE_C) begin
                        rx_noise_r <= rx_noise_r | rx_split;
                        if ((rx_bit_r == `AST_BIT_START) & rx_maj) begin
                            rx_state_r <= AST_RX_IDLE;
                        end else if (rx_stop) begin
                            // Ending at mid stop bit leaves room to catch the next edge.
                            rx_state_r <= AST_RX_IDLE;
                        end else if (rx_bit_r != `AST_BIT_START) begin
                            rx_shift_r[rx_bit_r - `AST_BIT_ONE] <= rx_maj;
                        end
                        rx_bit_r <= rx_bit_r + 4'h1;
                    end
                end
                default: begin
                    rx_state_r <= AST_RX_IDLE;
                end
            endcase
        end
    end

    // Line-idle timing counts sample ticks of continuous high level.
    always_ff @(posedge mclk) begin
        if (reset) begin
            idle_cnt_r <= `AST_IDLE_CNT_RST;
            line_act_r <= 1'b0;
        end else if (os_tick_r) begin
            if (~serial_in | (rx_state_r == AST_RX_FRAME)) begin
                idle_cnt_r <= `AST_IDLE_CNT_RST;
            end else if (idle_cnt_r != idle_frame) begin
                idle_cnt_r <= idle_cnt_r + 8'h01;
            end
            if (rx_enable & (rx_state_r == AST_RX_IDLE) & rx_prev_r & ~serial_in) begin
                line_act_r <= 1'b1;
            end else if (idle_event) begin
                line_act_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_sleep <= 1'b0;
            rx_active_flag <= 1'b0;
        end else begin
            if (idle_event) begin
                rx_sleep <= 1'b0;
            end else if (rx_sleep_set) begin
                rx_sleep <= 1'b1;
            end
            if (idle_event) begin
                rx_active_flag <= 1'b0;
            end else if (line_act_r & ~rx_sleep) begin
                rx_active_flag <= 1'b1;
            end
        end
    end

    // Clears are applied first so a same-cycle hardware set wins.
    always_ff @(posedge mclk) begin
        if (reset) begin
            rx_holding_reg <= `AST_WORD_RST;
            rx_holding_full <= `AST_RX_FLAGS_RST;
            parity_flag <= `AST_RX_FLAGS_RST;
            framing_flag <= `AST_RX_FLAGS_RST;
            noise_flag <= `AST_RX_FLAGS_RST;
            overrun_flag <= `AST_RX_FLAGS_RST;
            idle_flag <= `AST_RX_FLAGS_RST;
        end else begin
            if (rx_clr[0]) rx_holding_full <= 1'b0;
            if (rx_clr[1]) parity_flag <= 1'b0;
            if (rx_clr[2]) framing_flag <= 1'b0;
            if (rx_clr[3]) noise_flag <= 1'b0;
            if (rx_clr[4]) overrun_flag <= 1'b0;
            if (rx_clr[5]) idle_flag <= 1'b0;
            if (idle_event & ~rx_sleep) begin
                idle_flag <= 1'b1;
            end
            if (rx_done & ~rx_sleep) begin
                if (rx_holding_full & ~rx_clr[0]) begin
                    overrun_flag <= 1'b1;
                end else if (~(framing_flag & ~rx_clr[2])) begin
                    rx_holding_reg <= word_9bit ? rx_shift_r
                                                : {1'b0, rx_shift_r[7:0]};
                    rx_holding_full <= 1'b1;
                    noise_flag <= rx_noise_r | rx_split;
                    framing_flag <= ~rx_maj;
                    parity_flag <= parity_enable & rx_par_bad;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Combined service request.

    always_ff @(posedge mclk) begin
        if (reset) begin
            irq_req <= 1'b0;
        end else begin
            irq_req <= (tx_holding_empty & tx_holding_irq_en)
                     | (tx_complete & tx_complete_irq_en)
                     | ((rx_holding_full | overrun_flag) & rx_irq_en)
                     | (idle_flag & idle_irq_en);
        end
    end

endmodule // ast_uart

`default_nettype wire

/* verif/ast_uart_monitor.sv */
// Concurrent checks on the serial transceiver ports.
`timescale 1ns/1ps
`default_nettype none
module ast_uart_monitor (
    input wire logic mclk,
    input wire logic reset,
    input wire logic tx_enable,
    input wire logic status_rd,
    input wire logic data_rd,
    input wire logic data_wr,
    input wire logic rx_irq_en,
    input wire logic tx_holding_irq_en,
    input wire logic tx_complete_irq_en,
    input wire logic idle_irq_en,
    input wire logic serial_out,
    input wire logic tx_pin_oe_n,
    input wire ast_pkg::ast_word_t rx_holding_reg,
    input wire logic tx_holding_empty,
    input wire logic tx_complete,
    input wire logic rx_holding_full,
    input wire logic idle_flag,
    input wire logic overrun_flag,
    input wire logic framing_flag,
    input wire logic rx_active_flag,
    input wire logic irq_req
);
    import ast_pkg::*;
    logic any_src;
    default clocking dc @(posedge mclk);
    endclocking
    default disable iff (reset);
    assign any_src = (tx_holding_empty & tx_holding_irq_en) | (tx_complete & tx_complete_irq_en)
        | ((rx_holding_full | overrun_flag) & rx_irq_en) | (idle_flag & idle_irq_en);
    ////////////////////////////////////////
    a_reset_values: assert property (disable iff (1'b0) reset |=> tx_holding_empty &&
        tx_complete && serial_out && tx_pin_oe_n && !rx_holding_full && !irq_req)
        else $error("bad values after reset");
    a_pin_owned: assert property (tx_enable |=> !tx_pin_oe_n)
        else $error("tx pin released while enabled");
    // Every line bit lasts 32 cycles or more, so eight stable cycles is a safe floor.
    a_bit_width: assert property ($changed(serial_out) |=> $stable(serial_out) [*8])
        else $error("serial bit too short");
    a_rx_irq: assert property (rx_holding_full && rx_irq_en |=> irq_req)
        else $error("receive interrupt missing");
    a_irq_quiet: assert property (!any_src |=> !irq_req)
        else $error("interrupt without enabled source");
    a_overrun_keeps: assert property ($rose(overrun_flag) |->
        $stable(rx_holding_reg) && $past(rx_holding_full))
        else $error("overrun disturbed held word");
    a_framing_full: assert property ($rose(framing_flag) |-> rx_holding_full &&
        ($past(!rx_holding_full) || $past(data_rd)))
        else $error("framing flag without transfer");
    a_rx_clear: assert property (status_rd && rx_holding_full ##1
        data_rd && !rx_active_flag |=> !rx_holding_full)
        else $error("receive full not cleared");
    a_tx_clear: assert property (status_rd && tx_holding_empty ##1
        data_wr && tx_enable |=> !tx_holding_empty)
        else $error("holding empty not cleared");
endmodule // ast_uart_monitor

bind ast_uart ast_uart_monitor u_mon (.*);
`default_nettype wire

/* verif/ast_remote_node.sv */
// Remote serial node: sends frames to the receiver and logs frames from the transmitter.
`timescale 1ns/1ps
`default_nettype none
module ast_remote_node #(
    parameter int BIT_CYC = 32
) (
    input wire logic mclk,
    input wire logic nine_bits,
    input wire logic line_in,
    output logic line_out
);
    logic [9:0] seen_q[$];
    logic [9:0] frame;
    initial line_out = 1'b1;
    ////////////////////////////////////////
    // The glitch flips two cycles mid-cell so exactly one of three samples disagrees.
    task automatic send_frame(input logic [8:0] d, input logic stop, input logic glitch);
        logic [10:0] bits;
        bits = nine_bits ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
        for (int b = 0; b < (nine_bits ? 11 : 10); b++) begin
            for (int c = 0; c < BIT_CYC; c++) begin
                @(negedge mclk);
                line_out <= bits[b] ^ (glitch && b == 3 && c >= 16 && c < 18);
            end
        end
        @(negedge mclk);
        line_out <= 1'b1;
    endtask
    // Bits are taken mid-cell on the falling clock, away from the design's launch edge.
    always begin
        @(negedge line_in);
        repeat (BIT_CYC / 2) @(negedge mclk);
        frame = '1;
        for (int b = 0; b <= (nine_bits ? 9 : 8); b++) begin
            repeat (BIT_CYC) @(negedge mclk);
            frame = {line_in, frame[9:1]};
        end
        seen_q.push_back(nine_bits ? frame : frame >> 1);
    end
endmodule // ast_remote_node
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the serial transceiver.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ast_pkg::*;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic [12:0] baud_divisor = 13'h0001;
    logic word_9bit = 1'b0, parity_enable = 1'b0, parity_odd = 1'b0, tx_enable = 1'b0;
    logic rx_enable = 1'b0, rx_irq_en = 1'b0, idle_irq_en = 1'b0;
    logic status_rd = 1'b0, data_rd = 1'b0, data_wr = 1'b0;
    logic send_break = 1'b0, rx_sleep_set = 1'b0;
    logic tx_holding_irq_en = 1'b0, tx_complete_irq_en = 1'b0;
    ast_word_t wr_data = 9'h000;
    ast_word_t rx_holding_reg;
    logic serial_in, serial_out, tx_pin_oe_n, tx_holding_empty, tx_complete, rx_holding_full;
    logic idle_flag, overrun_flag, noise_flag, framing_flag, parity_flag, rx_active_flag, irq_req;
    logic rx_sleep;
    int failures = 0, comparisons = 0;
    always #50 mclk = ~mclk;
    ast_uart uut (.*);
    ast_remote_node peer (.mclk(mclk), .nine_bits(word_9bit), .line_in(serial_out),
        .line_out(serial_in));
    ////////////////////////////////////////
    task automatic check(input logic [9:0] got, input logic [9:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("failures %0d comparisons %0d", failures, comparisons);
        if (failures == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wait_hi(ref logic sig, input int lim);
        for (int i = 0; i < lim && sig !== 1'b1; i++) @(negedge mclk);
    endtask
    // A status read must come first, or the following access clears nothing.
    task automatic clear_seq(input logic wr, input ast_word_t d);
        @(negedge mclk);
        status_rd = 1'b1;
        @(negedge mclk);
        status_rd = 1'b0;
        data_rd = !wr;
        data_wr = wr;
        wr_data = d;
        @(negedge mclk);
        data_rd = 1'b0;
        data_wr = 1'b0;
    endtask
    ////////////////////////////////////////
    task automatic t_tx();
        check({tx_holding_empty, tx_complete, serial_out, tx_pin_oe_n}, 10'h00F);
        tx_enable = 1'b1;
        repeat (2) @(negedge mclk);
        check({tx_pin_oe_n, tx_holding_empty, tx_complete}, 10'h003);
        for (int m = 0; m < 2; m++) begin
            word_9bit = m[0];
            clear_seq(1'b1, 9'h1A5);
            wait_hi(tx_holding_empty, 500);
            clear_seq(1'b1, 9'h05A);
            check(tx_holding_empty, 10'h000);
            wait_hi(tx_complete, 1200);
            check(tx_complete, 10'h001);
            check(peer.seen_q.pop_front(), m ? 10'h3A5 : 10'h1A5);
            check(peer.seen_q.pop_front(), m ? 10'h25A : 10'h15A);
        end
    endtask
    task automatic t_disable();
        word_9bit = 1'b0;
        clear_seq(1'b1, 9'h0C3);
        wait_hi(tx_holding_empty, 400);
        clear_seq(1'b1, 9'h03C);
        tx_enable = 1'b0;
        wait_hi(tx_complete, 400);
        check({tx_complete, tx_holding_empty}, 10'h003);
        check(peer.seen_q.pop_front(), 10'h1C3);
        repeat (400) @(negedge mclk);
        check({tx_pin_oe_n, 9'(peer.seen_q.size())}, 10'h200);
    endtask
    // The break waits behind the preamble of ones that a fresh enable sends.
    task automatic t_break();
        int n;
        n = 0;
        tx_enable = 1'b1;
        send_break = 1'b1;
        for (int i = 0; i < 500 && serial_out; i++) @(negedge mclk);
        send_break = 1'b0;
        while (!serial_out && n < 500) begin
            @(negedge mclk);
            n++;
        end
        check(n[9:0], 10'h140);
        repeat (24) @(negedge mclk);
        check(serial_out, 10'h001);
        check(peer.seen_q.pop_front(), 10'h000);
        tx_enable = 1'b0;
        tx_holding_irq_en = 1'b1;
        repeat (2) @(negedge mclk);
        check(irq_req, 10'h001);
        tx_holding_irq_en = 1'b0;
        tx_complete_irq_en = 1'b1;
        repeat (2) @(negedge mclk);
        check(irq_req, 10'h001);
        tx_complete_irq_en = 1'b0;
        repeat (2) @(negedge mclk);
        check(irq_req, 10'h000);
    endtask
    task automatic t_sleep();
        rx_sleep_set = 1'b1;
        @(negedge mclk);
        rx_sleep_set = 1'b0;
        peer.send_frame(9'h011, 1'b1, 1'b0);
        check({rx_sleep, rx_holding_full, rx_active_flag}, 10'h004);
        repeat (400) @(negedge mclk);
        check({rx_sleep, idle_flag, rx_holding_full}, 10'h000);
    endtask
    task automatic t_rx_basic();
        rx_enable = 1'b1;
        rx_irq_en = 1'b1;
        idle_irq_en = 1'b1;
        peer.send_frame(9'h03C, 1'b1, 1'b0);
        wait_hi(rx_holding_full, 100);
        check(rx_holding_reg, 10'h03C);
        check({rx_active_flag, irq_req}, 10'h003);
        peer.send_frame(9'h0A5, 1'b1, 1'b0);
        wait_hi(overrun_flag, 100);
        check({overrun_flag, rx_holding_reg}, 10'h23C);
        wait_hi(idle_flag, 800);
        check({idle_flag, rx_active_flag}, 10'h002);
        clear_seq(1'b0, 9'h000);
        check({rx_holding_full, overrun_flag, idle_flag}, 10'h000);
        repeat (800) @(negedge mclk);
        check({idle_flag, irq_req}, 10'h000);
    endtask
    task automatic t_rx_case(input ast_word_t d, input logic stop, input logic glitch,
        input logic [1:0] par, input logic [2:0] flags);
        parity_enable = par[1];
        parity_odd = par[0];
        peer.send_frame(d, stop, glitch);
        wait_hi(rx_holding_full, 100);
        check(rx_holding_reg, d);
        check({noise_flag, framing_flag, parity_flag}, flags);
        clear_seq(1'b0, 9'h000);
        check({rx_holding_full, noise_flag, framing_flag, parity_flag}, 10'h000);
        repeat (64) @(negedge mclk);
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (20) @(negedge mclk);
        reset = 1'b0;
        @(negedge mclk);
        t_tx();
        t_disable();
        t_break();
        t_rx_basic();
        t_sleep();
        t_rx_case(9'h081, 1'b1, 1'b1, 2'b00, 3'b100);
        t_rx_case(9'h003, 1'b1, 1'b0, 2'b10, 3'b000);
        t_rx_case(9'h083, 1'b1, 1'b0, 2'b10, 3'b001);
        t_rx_case(9'h083, 1'b1, 1'b0, 2'b11, 3'b000);
        t_rx_case(9'h003, 1'b1, 1'b0, 2'b11, 3'b001);
        t_rx_case(9'h055, 1'b0, 1'b0, 2'b00, 3'b010);
        results();
    end
    initial begin
        #(40000 * 100);
        failures++;
        results();
    end
endmodule // tb_top
`default_nettype wire
